// ---- verilog/pwmtb_top.sv ----
// three pulse-width time bases with comparators behind an APB register slave
// assumes an APB master on clk_sys; events go to downstream waveform logic
//
// Behaviour
// RULE1: each generator has one 16-bit down or up/down counter and two comparators.
// RULE2: three identical generators, two pulse outputs each, six in total.
// RULE3: both outputs of a generator share its one counter, period and frequency.
// RULE4: down mode counts load value to zero, reloads, and repeats forever.
// RULE5: up/down mode counts zero to load, back to zero, and repeats.
// RULE6: direction is low in down mode and follows counting direction in up/down.
// RULE7: zero event pulses high for one cycle whenever the count is zero.
// RULE8: load event pulses high for one cycle whenever count equals load value.
// RULE9: in down mode the load pulse follows the zero pulse immediately.
// RULE10: each comparator pulses one cycle when the count equals its match value.
// RULE11: in up/down mode matches fire both ways, split into up and down events.
// RULE12: a match value above the load value never produces a pulse.
// RULE13: four events in down mode, six in up/down mode.
// RULE14: counter steps once per clock while enabled; settings come from configuration.
// RULE15: reset leaves count zero, direction low, and every event low.
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/100ps
module pwmtb_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pwmtb_pkg::ADDR_W-1:0] paddr,
    input wire logic [pwmtb_pkg::DATA_W-1:0] pwdata,
    output logic [pwmtb_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [pwmtb_pkg::GEN_COUNT-1:0] genDirUp,
    output logic [pwmtb_pkg::GEN_COUNT-1:0] genZero,
    output logic [pwmtb_pkg::GEN_COUNT-1:0] genLoad,
    output logic [pwmtb_pkg::GEN_COUNT-1:0] genMatchAUp,
    output logic [pwmtb_pkg::GEN_COUNT-1:0] genMatchADown,
    output logic [pwmtb_pkg::GEN_COUNT-1:0] genMatchBUp,
    output logic [pwmtb_pkg::GEN_COUNT-1:0] genMatchBDown
);
    import pwmtb_pkg::*;

    // ------------------------------------------------------------
    // address decoding
    // ------------------------------------------------------------
    function automatic logic regHit(
        input logic [ADDR_W-1:0] a,
        input int g,
        input logic [OFF_W-1:0] off
    );
        regHit = (a[GEN_SEL_LSB +: GEN_SEL_W] == GEN_SEL_W'(g)) && (a[OFF_W-1:0] == off);
    endfunction : regHit

    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        logic hit;
        hit = (a == ADDR_ENALL) || (a == ADDR_EVSUM);
        for (int g = 0; g < GEN_COUNT; g++) begin
            hit = hit || regHit(a, g, OFF_CTL) || regHit(a, g, OFF_LOAD)
                || regHit(a, g, OFF_CMPA) || regHit(a, g, OFF_CMPB)
                || regHit(a, g, OFF_COUNT) || regHit(a, g, OFF_EVENTS);
        end
        isMapped = hit;
    endfunction : isMapped

    // ------------------------------------------------------------
    // bus timing
    // ------------------------------------------------------------
    logic setupPhase;
    logic wrEn;
    logic [DATA_W-1:0] rdWord;

    // zero-wait slave: read data is captured in the setup cycle so that
    // prdata comes from a flop and the access phase can finish at once
    assign setupPhase = psel && !penable;
    assign pready = psel && penable;
    assign wrEn = psel && penable && pwrite;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [GEN_COUNT-1:0] ctlEnable;
    pwmtb_mode_e ctlMode [GEN_COUNT];
    pwmtb_cnt_t loadVal [GEN_COUNT];
    pwmtb_cnt_t cmpA [GEN_COUNT];
    pwmtb_cnt_t cmpB [GEN_COUNT];
    pwmtb_ev_t evSticky [GEN_COUNT];
    pwmtb_ev_t evNow [GEN_COUNT];
    pwmtb_cnt_t countRd [GEN_COUNT];
    logic [GEN_COUNT-1:0] evAny;

    // enable bits are reachable per generator and all at once, so that
    // several generators can be started in the same clock and stay in step
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctlEnable <= '0;
        end else if (wrEn && paddr == ADDR_ENALL) begin
            ctlEnable <= pwdata[GEN_COUNT-1:0]; // RULE14
        end else begin
            for (int g = 0; g < GEN_COUNT; g++) begin
                if (wrEn && regHit(paddr, g, OFF_CTL)) begin
                    ctlEnable[g] <= pwdata[CTL_EN_BIT]; // RULE14
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int g = 0; g < GEN_COUNT; g++) begin
                ctlMode[g] <= PWMTB_MODE_DOWN;
            end
        end else begin
            for (int g = 0; g < GEN_COUNT; g++) begin
                if (wrEn && regHit(paddr, g, OFF_CTL)) begin
                    ctlMode[g] <= pwmtb_mode_e'(pwdata[CTL_MODE_BIT]); // RULE14
                end
            end
        end
    end

    // load and match values take effect immediately; a change mid-period
    // can shorten or stretch the running period once
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int g = 0; g < GEN_COUNT; g++) begin
                loadVal[g] <= LOAD_RST;
            end
        end else begin
            for (int g = 0; g < GEN_COUNT; g++) begin
                if (wrEn && regHit(paddr, g, OFF_LOAD)) begin
                    loadVal[g] <= pwdata[CNT_W-1:0]; // RULE14
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int g = 0; g < GEN_COUNT; g++) begin
                cmpA[g] <= CMP_RST;
                cmpB[g] <= CMP_RST;
            end
        end else begin
            for (int g = 0; g < GEN_COUNT; g++) begin
                if (wrEn && regHit(paddr, g, OFF_CMPA)) begin
                    cmpA[g] <= pwdata[CNT_W-1:0]; // RULE14
                end
                if (wrEn && regHit(paddr, g, OFF_CMPB)) begin
                    cmpB[g] <= pwdata[CNT_W-1:0]; // RULE14
                end
            end
        end
    end

    // ------------------------------------------------------------
    // sticky event record, write one to clear
    // ------------------------------------------------------------
    // a new event in the clearing cycle survives the clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int g = 0; g < GEN_COUNT; g++) begin
                evSticky[g] <= EV_RST;
            end
        end else begin
            for (int g = 0; g < GEN_COUNT; g++) begin
                if (wrEn && regHit(paddr, g, OFF_EVENTS)) begin
                    evSticky[g] <= (evSticky[g] & ~pwdata[EV_W-1:0]) | evNow[g];
                end else begin
                    evSticky[g] <= evSticky[g] | evNow[g];
                end
            end
        end
    end

    always_comb begin
        for (int g = 0; g < GEN_COUNT; g++) begin
            evAny[g] = |evSticky[g];
        end
    end

    // ------------------------------------------------------------
    // generators
    // ------------------------------------------------------------
    for (genvar g = 0; g < GEN_COUNT; g++) begin : gen_slot // RULE2
        pwmtb_gen_if genBus ();

        assign genBus.enable = ctlEnable[g];
        assign genBus.mode = ctlMode[g];
        assign genBus.loadVal = loadVal[g];
        assign genBus.cmpA = cmpA[g];
        assign genBus.cmpB = cmpB[g];

        // one counter feeds both comparators, so the two outputs
        // downstream can never drift apart in period
        pwmtb_timebase u_timebase (
            .clk_sys(clk_sys),
            .rst(rst),
            .gen(genBus.tbase)
        ); // RULE1 RULE3

        assign evNow[g] = {genBus.matchBDown, genBus.matchBUp, genBus.matchADown,
                           genBus.matchAUp, genBus.loadEv, genBus.zeroEv}; // RULE13
        assign countRd[g] = genBus.count;
        assign genDirUp[g] = genBus.dirUp;
        assign genZero[g] = genBus.zeroEv;
        assign genLoad[g] = genBus.loadEv;
        assign genMatchAUp[g] = genBus.matchAUp;
        assign genMatchADown[g] = genBus.matchADown;
        assign genMatchBUp[g] = genBus.matchBUp;
        assign genMatchBDown[g] = genBus.matchBDown;
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        rdWord = '0;
        if (paddr == ADDR_ENALL) begin
            rdWord[GEN_COUNT-1:0] = ctlEnable;
        end
        if (paddr == ADDR_EVSUM) begin
            rdWord[GEN_COUNT-1:0] = evAny;
        end
        for (int g = 0; g < GEN_COUNT; g++) begin
            if (regHit(paddr, g, OFF_CTL)) begin
                rdWord[CTL_EN_BIT] = ctlEnable[g];
                rdWord[CTL_MODE_BIT] = ctlMode[g];
            end
            if (regHit(paddr, g, OFF_LOAD)) begin
                rdWord[CNT_W-1:0] = loadVal[g];
            end
            if (regHit(paddr, g, OFF_CMPA)) begin
                rdWord[CNT_W-1:0] = cmpA[g];
            end
            if (regHit(paddr, g, OFF_CMPB)) begin
                rdWord[CNT_W-1:0] = cmpB[g];
            end
            if (regHit(paddr, g, OFF_COUNT)) begin
                rdWord[CNT_W-1:0] = countRd[g];
                rdWord[COUNT_DIR_BIT] = genDirUp[g];
            end
            if (regHit(paddr, g, OFF_EVENTS)) begin
                rdWord[EV_W-1:0] = evSticky[g];
            end
        end
    end

    // the answer is fixed in the setup cycle and held through the access;
    // unmapped addresses read zero and flag an error, writes to them are dropped
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            prdata <= pwrite ? '0 : rdWord;
            pslverr <= !isMapped(paddr);
        end
    end

endmodule : pwmtb_top

// ---- verilog/pwmtb_pkg.sv ----
// constants and types shared by the pulse-width time base and its register slave
// assumes one 100 MHz system clock and a 32-bit APB register bus
package pwmtb_pkg;

    // ------------------------------------------------------------
    // structure
    // ------------------------------------------------------------
    localparam int GEN_COUNT = 3;
    localparam int CNT_W = 16;
    localparam int EV_W = 6;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int OFF_W = 5;
    localparam int GEN_SEL_LSB = 5;
    localparam int GEN_SEL_W = 3;

    // ------------------------------------------------------------
    // register map, byte offsets within one generator slot and the two shared addresses
    // ------------------------------------------------------------
    localparam logic [OFF_W-1:0] OFF_CTL = 5'h00;
    localparam logic [OFF_W-1:0] OFF_LOAD = 5'h04;
    localparam logic [OFF_W-1:0] OFF_CMPA = 5'h08;
    localparam logic [OFF_W-1:0] OFF_CMPB = 5'h0C;
    localparam logic [OFF_W-1:0] OFF_COUNT = 5'h10;
    localparam logic [OFF_W-1:0] OFF_EVENTS = 5'h14;
    localparam logic [ADDR_W-1:0] ADDR_ENALL = 8'h60;
    localparam logic [ADDR_W-1:0] ADDR_EVSUM = 8'h64;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_MODE_BIT = 1;
    localparam int COUNT_DIR_BIT = 16;
    localparam int EV_ZERO = 0;
    localparam int EV_LOAD = 1;
    localparam int EV_A_UP = 2;
    localparam int EV_A_DOWN = 3;
    localparam int EV_B_UP = 4;
    localparam int EV_B_DOWN = 5;

    // ------------------------------------------------------------
    // reset values and the counter step
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] LOAD_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
    localparam logic [EV_W-1:0] EV_RST = 6'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    typedef logic [CNT_W-1:0] pwmtb_cnt_t;
    typedef logic [EV_W-1:0] pwmtb_ev_t;
    typedef enum logic {
        PWMTB_MODE_DOWN = 1'b0,
        PWMTB_MODE_UPDOWN = 1'b1
    } pwmtb_mode_e;

endpackage : pwmtb_pkg

// ---- verilog/pwmtb_gen_if.sv ----
// configuration and event bundle between the register slave and one time base
// assumes both ends sit in the clk_sys domain
`timescale 1ns/100ps
interface pwmtb_gen_if;
    import pwmtb_pkg::*;

    logic enable;
    pwmtb_mode_e mode;
    pwmtb_cnt_t loadVal;
    pwmtb_cnt_t cmpA;
    pwmtb_cnt_t cmpB;
    pwmtb_cnt_t count;
    logic dirUp;
    logic zeroEv;
    logic loadEv;
    logic matchAUp;
    logic matchADown;
    logic matchBUp;
    logic matchBDown;

    modport ctrl (output enable, mode, loadVal, cmpA, cmpB,
                  input count, dirUp, zeroEv, loadEv, matchAUp, matchADown, matchBUp,
                  matchBDown);
    modport tbase (input enable, mode, loadVal, cmpA, cmpB,
                   output count, dirUp, zeroEv, loadEv, matchAUp, matchADown, matchBUp,
                   matchBDown);
endinterface : pwmtb_gen_if

// ---- verilog/pwmtb_timebase.sv ----
// one generator's 16-bit counter with its two direction-qualified comparators
// assumes configuration is steady or changes only between clk_sys edges
`timescale 1ns/100ps
module pwmtb_timebase (
    input wire logic clk_sys,
    input wire logic rst,
    pwmtb_gen_if.tbase gen
);
    import pwmtb_pkg::*;

    pwmtb_cnt_t count;
    logic dirUp;
    pwmtb_cnt_t next_count;
    logic next_dirUp;
    logic hitA;
    logic hitB;

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_comb begin
        next_count = count;
        next_dirUp = dirUp;
        if (gen.enable) begin
            if (gen.mode == PWMTB_MODE_DOWN) begin
                next_dirUp = 1'b0; // RULE6
                // a count left above a lowered load reloads at once
                if (count == CNT_RST || count > gen.loadVal) begin
                    next_count = gen.loadVal; // RULE4 RULE9
                end else begin
                    next_count = count - CNT_ONE; // RULE4
                end
            end else if (dirUp) begin
                if (count >= gen.loadVal) begin
                    next_dirUp = 1'b0; // RULE6
                    next_count = (count == CNT_RST) ? CNT_RST : count - CNT_ONE; // RULE5
                end else begin
                    next_count = count + CNT_ONE; // RULE5
                end
            end else if (count == CNT_RST) begin
                next_dirUp = 1'b1; // RULE6
                next_count = (gen.loadVal == CNT_RST) ? CNT_RST : CNT_ONE; // RULE5
            end else begin
                next_count = count - CNT_ONE; // RULE5
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count <= CNT_RST; // RULE15
            dirUp <= 1'b0; // RULE15
        end else begin
            count <= next_count; // RULE1 RULE14
            dirUp <= next_dirUp;
        end
    end

    // ------------------------------------------------------------
    // events, registered so they line up with the count they describe
    // ------------------------------------------------------------
    assign hitA = (next_count == gen.cmpA) && (gen.cmpA <= gen.loadVal); // RULE10 RULE12
    assign hitB = (next_count == gen.cmpB) && (gen.cmpB <= gen.loadVal); // RULE10 RULE12

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gen.zeroEv <= 1'b0; // RULE15
            gen.loadEv <= 1'b0;
            gen.matchAUp <= 1'b0;
            gen.matchADown <= 1'b0;
            gen.matchBUp <= 1'b0;
            gen.matchBDown <= 1'b0;
        end else begin
            gen.zeroEv <= gen.enable && (next_count == CNT_RST); // RULE7
            gen.loadEv <= gen.enable && (next_count == gen.loadVal); // RULE8
            gen.matchAUp <= gen.enable && hitA && next_dirUp; // RULE11 RULE13
            gen.matchADown <= gen.enable && hitA && !next_dirUp; // RULE11 RULE13
            gen.matchBUp <= gen.enable && hitB && next_dirUp; // RULE11 RULE13
            gen.matchBDown <= gen.enable && hitB && !next_dirUp; // RULE11 RULE13
        end
    end

    assign gen.count = count;
    assign gen.dirUp = dirUp;

endmodule : pwmtb_timebase

// ---- dv/pwmtb_top_properties.sv ----
// concurrent checks on the ports of the three pulse-width time bases
// assumes one clk_sys domain and the asynchronous active-high rst
`timescale 1ns/100ps
module pwmtb_top_properties import pwmtb_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pwmtb_pkg::ADDR_W-1:0] paddr,
    input wire logic [pwmtb_pkg::DATA_W-1:0] pwdata,
    input wire logic [pwmtb_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [pwmtb_pkg::GEN_COUNT-1:0] genDirUp,
    input wire logic [pwmtb_pkg::GEN_COUNT-1:0] genZero,
    input wire logic [pwmtb_pkg::GEN_COUNT-1:0] genLoad,
    input wire logic [pwmtb_pkg::GEN_COUNT-1:0] genMatchAUp,
    input wire logic [pwmtb_pkg::GEN_COUNT-1:0] genMatchADown,
    input wire logic [pwmtb_pkg::GEN_COUNT-1:0] genMatchBUp,
    input wire logic [pwmtb_pkg::GEN_COUNT-1:0] genMatchBDown
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    apb_ready_a: assert property (psel && penable |-> pready) else $error("no ready in access");
    unmapped_err_a: assert property (psel && !penable && paddr >= 8'h68 |=> pslverr) else
        $error("unmapped address without error");

    for (genvar g = 0; g < GEN_COUNT; g++) begin : gen_chk
        // load equal to zero makes both events stand together, so those cycles are left out
        sequence zeroAlone;
            genZero[g] && !genLoad[g];
        endsequence
        sequence reloadOrClimb;
            genLoad[g] || genDirUp[g] || !(genZero[g] || genMatchADown[g] || genMatchBDown[g]);
        endsequence
        zero_pulse_a: assert property (zeroAlone |=> !genZero[g]) else $error("zero too long");
        load_pulse_a: assert property (genLoad[g] && !genZero[g] |=> !genLoad[g]) else
            $error("load too long");
        zero_then_load_a: assert property (zeroAlone |=> reloadOrClimb) else
            $error("no reload after zero");
        zero_dir_a: assert property (genZero[g] |-> !genDirUp[g]) else $error("zero while up");
        up_match_a: assert property (genMatchAUp[g] || genMatchBUp[g] |-> genDirUp[g]) else
            $error("up match while down");
        down_match_a: assert property (genMatchADown[g] || genMatchBDown[g] |-> !genDirUp[g]) else
            $error("down match while up");
        reset_quiet_a: assert property ($fell(rst) |-> !genDirUp[g] && !genZero[g] && !genLoad[g])
            else $error("outputs not clear after reset");
    end
endmodule : pwmtb_top_properties

bind pwmtb_top pwmtb_top_properties i_pwmtb_top_properties (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .genDirUp(genDirUp), .genZero(genZero),
    .genLoad(genLoad), .genMatchAUp(genMatchAUp), .genMatchADown(genMatchADown),
    .genMatchBUp(genMatchBUp), .genMatchBDown(genMatchBDown));

// ---- dv/pwmtb_wave_model.sv ----
// downstream waveform stage: one center-aligned output per generator
// assumes direction-qualified match pulses in the clk_sys domain
`timescale 1ns/100ps
module pwmtb_wave_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [pwmtb_pkg::GEN_COUNT-1:0] matchUp,
    input wire logic [pwmtb_pkg::GEN_COUNT-1:0] matchDown,
    output logic [pwmtb_pkg::GEN_COUNT-1:0] waveA
);
    import pwmtb_pkg::*;
    // high on the rising match, low on the falling one
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            waveA <= '0;
        end else begin
            waveA <= (waveA | matchUp) & ~matchDown;
        end
    end
endmodule : pwmtb_wave_model

// ---- dv/tb_top.sv ----
// self-checking bench: APB set-up of three time bases and a reference counter model
// assumes pwmtb_top answers APB with zero wait states
`timescale 1ns/100ps
module tb_top;
    import pwmtb_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic pready, pslverr;
    logic [GEN_COUNT-1:0] genDirUp, genZero, genLoad, genMatchAUp, genMatchADown;
    logic [GEN_COUNT-1:0] genMatchBUp, genMatchBDown, waveA, refWave, re, rm, rd, run;
    logic [CNT_W-1:0] rc[GEN_COUNT], rl[GEN_COUNT], ra[GEN_COUNT], rb[GEN_COUNT];
    logic [EV_W-1:0] stky[GEN_COUNT];
    logic [CNT_W-1:0] ld;
    logic [32:0] expQ[$];
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    always #5 clk_sys = ~clk_sys;

    pwmtb_top i_pwmtb_top (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .genDirUp(genDirUp), .genZero(genZero), .genLoad(genLoad),
        .genMatchAUp(genMatchAUp), .genMatchADown(genMatchADown), .genMatchBUp(genMatchBUp),
        .genMatchBDown(genMatchBDown));
    pwmtb_wave_model i_pwmtb_wave_model (.clk_sys(clk_sys), .rst(rst), .matchUp(genMatchAUp),
        .matchDown(genMatchADown), .waveA(waveA));

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chkEvents(input logic [6:0] got, input logic [6:0] exp);
        chk({26'h0, got}, {26'h0, exp});
    endtask : chkEvents

    task automatic chkWave(input logic [GEN_COUNT-1:0] got, input logic [GEN_COUNT-1:0] exp);
        chk({30'h0, got}, {30'h0, exp});
    endtask : chkWave

    task automatic stop_test;
        // a read still queued was never answered
        num_errors += expQ.size();
        $display("errors=%0d checks=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    // x carries the expected {pslverr, prdata} of a read
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [32:0] x);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr) begin
            expQ.push_back(x);
        end
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    always @(posedge clk_sys) begin
        if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
            chk({pslverr, prdata}, expQ.pop_front());
        end
    end

    // --------------------------------------------------------------
    // reference counters, mirrored from the APB writes
    // --------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            re <= '0;
            rm <= '0;
            rd <= '0;
            run <= '0;
            for (int g = 0; g < GEN_COUNT; g++) begin
                rc[g] <= '0;
                rl[g] <= '0;
                ra[g] <= '0;
                rb[g] <= '0;
            end
        end else begin
            run <= re;
            for (int g = 0; g < GEN_COUNT; g++) begin
                logic up;
                up = !(rd[g] && rc[g] >= rl[g]) && (rd[g] || rc[g] == '0);
                if (!rm[g]) begin
                    rd[g] <= 1'b0;
                end
                if (re[g] && !rm[g]) begin
                    rc[g] <= (rc[g] == '0 || rc[g] > rl[g]) ? rl[g] : rc[g] - CNT_ONE;
                end else if (re[g]) begin
                    rc[g] <= up ? rc[g] + CNT_ONE : rc[g] - CNT_ONE;
                    rd[g] <= up;
                end
            end
            if (psel && penable && pwrite && paddr == ADDR_ENALL) begin
                re <= pwdata[GEN_COUNT-1:0];
            end else if (psel && penable && pwrite && paddr < ADDR_ENALL) begin
                case (paddr[OFF_W-1:0])
                    OFF_CTL: begin
                        re[paddr[6:5]] <= pwdata[CTL_EN_BIT];
                        rm[paddr[6:5]] <= pwdata[CTL_MODE_BIT];
                    end
                    OFF_LOAD: rl[paddr[6:5]] <= pwdata[CNT_W-1:0];
                    OFF_CMPA: ra[paddr[6:5]] <= pwdata[CNT_W-1:0];
                    OFF_CMPB: rb[paddr[6:5]] <= pwdata[CNT_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    always @(negedge clk_sys) begin
        if (!rst) begin
            for (int g = 0; g < GEN_COUNT; g++) begin
                logic [6:0] e;
                e = {rd[g], run[g] && rc[g] == '0, run[g] && rc[g] == rl[g],
                     run[g] && rc[g] == ra[g] && rd[g], run[g] && rc[g] == ra[g] && !rd[g],
                     run[g] && rc[g] == rb[g] && rd[g], run[g] && rc[g] == rb[g] && !rd[g]};
                chkEvents({genDirUp[g], genZero[g], genLoad[g], genMatchAUp[g], genMatchADown[g],
                           genMatchBUp[g], genMatchBDown[g]}, e);
                stky[g] = stky[g] | {e[0], e[1], e[2], e[3], e[4], e[5]};
                refWave[g] = (refWave[g] | e[3]) & ~e[2];
            end
        end else begin
            refWave = '0;
        end
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            stop_test();
        end
    end

    initial begin
        void'($urandom(16));
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        for (int g = 0; g < GEN_COUNT; g++) begin
            stky[g] = '0;
            apb(1'b0, {3'(g), OFF_CTL}, '0, 33'h0);
            apb(1'b0, {3'(g), OFF_COUNT}, '0, 33'h0);
        end
        apb(1'b0, 8'h18, '0, {1'b1, 32'h0});
        apb(1'b0, 8'h70, '0, {1'b1, 32'h0});
        // generator one runs up/down, the others count down
        for (int g = 0; g < GEN_COUNT; g++) begin
            ld = 16'(2 + $urandom_range(7));
            apb(1'b1, {3'(g), OFF_CTL}, {30'h0, g == 1, 1'b0}, '0);
            apb(1'b1, {3'(g), OFF_LOAD}, {16'h0, ld}, '0);
            apb(1'b1, {3'(g), OFF_CMPA}, g == 2 ? {16'h0, ld} : 32'($urandom_range(ld)), '0);
            apb(1'b1, {3'(g), OFF_CMPB}, g == 0 ? 32'(ld + 1) : (g == 1 ? 32'(ld) : 0), '0);
        end
        // generator one is started through its own enable bit first
        apb(1'b1, {3'h1, OFF_CTL}, 32'h3, '0);
        apb(1'b1, ADDR_ENALL, 32'h7, '0);
        apb(1'b0, ADDR_ENALL, '0, 33'h7);
        repeat (80) @(posedge clk_sys);
        apb(1'b1, ADDR_ENALL, '0, '0);
        apb(1'b1, {3'h0, OFF_COUNT}, 32'hFFFF, '0);
        for (int g = 0; g < GEN_COUNT; g++) begin
            apb(1'b0, {3'(g), OFF_COUNT}, '0, {16'h0, rd[g], rc[g]});
            apb(1'b0, {3'(g), OFF_EVENTS}, '0, {27'h0, stky[g]});
            apb(1'b1, {3'(g), OFF_EVENTS}, 32'h3F, '0);
            apb(1'b0, {3'(g), OFF_EVENTS}, '0, 33'h0);
        end
        apb(1'b0, ADDR_EVSUM, '0, 33'h0);
        chkWave(waveA, refWave);
        rst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        apb(1'b0, {3'h1, OFF_CTL}, '0, 33'h0);
        apb(1'b0, {3'h1, OFF_COUNT}, '0, 33'h0);
        repeat (2) @(posedge clk_sys);
        stop_test();
    end
endmodule : tb_top
